/* design/ipd_params.svh */
// Function
// - Idle halts core execution; peripherals and interrupt logic keep their clock.
// - Idle keeps internal RAM and special function registers unchanged.
// - Idle ends on any enabled active interrupt or on hardware reset.
// - Reset out of idle blocks RAM writes for two machine cycles, not ports.
// - Idle drives both strobes 1, power-down 0; port float/address per memory.
// - Power-down stops the oscillator after the requesting instruction completes.
// - Power-down keeps RAM and special function registers until exit.
// - Power-down exits only on hardware reset or enabled external interrupt.
// - Reset out of power-down restores registers but keeps RAM contents.
// - With wake edge select set, service starts at the pin's rising edge.
// - With wake edge select clear, resume 2 ms after the pin's falling edge.
`ifndef IPD_PARAMS_SVH
`define IPD_PARAMS_SVH

`define IPD_CLK_PERIOD_NS   10
`define IPD_WAKE_DELAY_MS   2
`define IPD_WAKE_CYCLES     ((`IPD_WAKE_DELAY_MS * 1000000) / `IPD_CLK_PERIOD_NS)
`define IPD_MC_CYCLES       12
`define IPD_BLOCK_MCS       2
`define IPD_BLOCK_CYCLES    (`IPD_MC_CYCLES * `IPD_BLOCK_MCS)
`define IPD_CNT_W           18
`define IPD_CTRL_RST        2'b00

`endif

/* design/ipd_pkg.sv */
package ipd_pkg;
    typedef enum logic [1:0] {
        IPD_RUN,
        IPD_IDLE,
        IPD_PDOWN,
        IPD_WAKE
    } ipd_state_t;
endpackage : ipd_pkg

/* design/ipd_wake_if.sv */
`timescale 1ns/1ps
// Wake request from the sequencer to the timer, with busy and done back
interface ipd_wake_if;
    logic start;
    logic busy;
    logic done;
    modport seq (output start, input busy, input done);
    modport tmr (input start, output busy, output done);
endinterface : ipd_wake_if

/* design/ipd_wake_timer.sv */
`timescale 1ns/1ps
`include "ipd_params.svh"
module ipd_wake_timer
    import ipd_pkg::*;
#(
    parameter int unsigned WAKE_CYCLES = `IPD_WAKE_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    ipd_wake_if.tmr   wk
);
    logic [`IPD_CNT_W-1:0] cnt_ff;
    logic [`IPD_CNT_W-1:0] nxt_cnt;
    logic                  busy_ff;
    logic                  done_ff;
    wire                   last = busy_ff && (cnt_ff == '0);

    // Self-timed resume count after the waking falling edge
    assign nxt_cnt = wk.start ? `IPD_CNT_W'(WAKE_CYCLES - 1) :
                     (busy_ff && !last) ? cnt_ff - `IPD_CNT_W'(1) : cnt_ff;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_ff  <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            busy_ff <= wk.start | (busy_ff & !last);
            done_ff <= last & !wk.start;
        end
    end
    assign wk.busy = busy_ff;
    assign wk.done = done_ff;
endmodule : ipd_wake_timer

/* design/ipd_ram_guard.sv */
`timescale 1ns/1ps
`include "ipd_params.svh"
module ipd_ram_guard
    import ipd_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      block
);
    logic [4:0] cnt_ff;

    // Hold RAM writes off while the core may still run after reset
    always_ff @(posedge ref_clk) begin
        if (start) begin
            cnt_ff <= 5'(`IPD_BLOCK_CYCLES);
        end else if (cnt_ff != 5'h0) begin
            cnt_ff <= cnt_ff - 5'h1;
        end else if (!rst_n) begin
            cnt_ff <= 5'h0;
        end
    end
    assign block = (cnt_ff != 5'h0);
endmodule : ipd_ram_guard

/* design/ipd_power_ctrl.sv */
`timescale 1ns/1ps
`include "ipd_params.svh"
// ************************************************
// Idle and power-down sequencer
// ************************************************
module ipd_power_ctrl
    import ipd_pkg::*;
#(
    parameter int unsigned WAKE_CYCLES = `IPD_WAKE_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic idle_req_set,
    input  wire logic pdown_req_set,
    input  wire logic wake_edge_select,
    input  wire logic ext_prog_mem,
    input  wire logic irq_pending,
    input  wire logic ext_irq0_en,
    input  wire logic ext_irq1_en,
    input  wire logic ext_irq0_pin,
    input  wire logic ext_irq1_pin,
    input  wire logic core_ale,
    input  wire logic core_prog_store_strobe,
    input  wire logic ram_we_req,
    output logic      core_run,
    output logic      osc_run,
    output logic      periph_clk_en,
    output logic      sfr_hold,
    output logic      sfr_reset,
    output logic      ram_we,
    output logic      idle_bit,
    output logic      pdown_bit,
    output logic      addr_latch_strobe,
    output logic      prog_store_strobe,
    output logic      port0_float,
    output logic      port2_addr_en,
    output logic      isr_start
);
    ipd_state_t state_ff;
    ipd_state_t nxt_state;
    logic [1:0] ctrl_ff;
    logic       irq0_d_ff;
    logic       irq1_d_ff;
    logic       core_run_ff;
    logic       osc_ff;
    logic       pclk_ff;
    logic       hold_ff;
    logic       sfr_rst_ff;
    logic       we_ff;
    logic       ale_ff;
    logic       prog_store_strobe_ff;
    logic       p0f_ff;
    logic       p2a_ff;
    logic       isr_ff;
    logic       was_idle_ff;
    logic       ram_block;

    ipd_wake_if wk ();

    ipd_wake_timer #(.WAKE_CYCLES(WAKE_CYCLES)) u_timer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .wk      (wk.tmr)
    );

    // ************************************************
    // Wake sources
    // ************************************************
    wire ext0_low  = ext_irq0_en && !ext_irq0_pin;
    wire ext1_low  = ext_irq1_en && !ext_irq1_pin;
    wire ext_low   = ext0_low || ext1_low;
    wire ext_fall  = (ext_irq0_en && irq0_d_ff && !ext_irq0_pin) ||
                     (ext_irq1_en && irq1_d_ff && !ext_irq1_pin);
    wire ext_rise  = (ext_irq0_en && !irq0_d_ff && ext_irq0_pin) ||
                     (ext_irq1_en && !irq1_d_ff && ext_irq1_pin);
    wire pd_sel    = ctrl_ff[1];
    wire in_idle   = (state_ff == IPD_IDLE);
    wire in_pd     = (state_ff == IPD_PDOWN) || (state_ff == IPD_WAKE);
    wire wake_go   = (state_ff == IPD_WAKE) &&
                     (wake_edge_select ? ext_rise : wk.done);
    assign wk.start = (state_ff == IPD_PDOWN) && ext_fall && !wake_edge_select;

    // Next state; only reset or an enabled external pin leaves power-down
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            IPD_RUN: begin
                if (pd_sel) begin
                    nxt_state = IPD_PDOWN;
                end else if (ctrl_ff[0]) begin
                    nxt_state = IPD_IDLE;
                end
            end
            IPD_IDLE: begin
                if (irq_pending) begin
                    nxt_state = IPD_RUN;
                end
            end
            IPD_PDOWN: begin
                if (ext_low) begin
                    nxt_state = IPD_WAKE;
                end
            end
            IPD_WAKE: begin
                if (wake_go) begin
                    nxt_state = IPD_RUN;
                end
            end
            default: nxt_state = IPD_RUN;
        endcase
    end

    // Request bits: set by software, cleared by hardware on exit
    wire [1:0] nxt_ctrl = (state_ff != IPD_RUN && nxt_state == IPD_RUN) ? 2'b00 :
                          (ctrl_ff | {pdown_req_set, idle_req_set});

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_ff  <= IPD_RUN;
            ctrl_ff   <= `IPD_CTRL_RST;
            irq0_d_ff <= 1'b1;
            irq1_d_ff <= 1'b1;
        end else begin
            state_ff  <= nxt_state;
            ctrl_ff   <= nxt_ctrl;
            irq0_d_ff <= ext_irq0_pin;
            irq1_d_ff <= ext_irq1_pin;
        end
    end

    // Remember idle so a reset ending it opens the RAM write guard
    always_ff @(posedge ref_clk) begin
        was_idle_ff <= rst_n ? in_idle : 1'b0;
    end
    ipd_ram_guard u_guard (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .start   (!rst_n && was_idle_ff),
        .block   (ram_block)
    );

    // ************************************************
    // Registered outputs
    // ************************************************
    wire nxt_core_run = (nxt_state == IPD_RUN);
    wire nxt_osc      = !((nxt_state == IPD_PDOWN) ||
                          (nxt_state == IPD_WAKE && !wk.done && !ext_rise));
    wire nxt_pclk     = (nxt_state == IPD_RUN) || (nxt_state == IPD_IDLE);
    wire nxt_hold     = (nxt_state != IPD_RUN);
    wire nxt_we       = ram_we_req && (nxt_state == IPD_RUN) && !ram_block;
    wire nxt_idle_o   = (nxt_state == IPD_IDLE);
    wire nxt_pd_o     = (nxt_state == IPD_PDOWN) || (nxt_state == IPD_WAKE);
    wire nxt_ale      = nxt_idle_o ? 1'b1 : nxt_pd_o ? 1'b0 : core_ale;
    wire nxt_prog_store_strobe     = nxt_idle_o ? 1'b1 : nxt_pd_o ? 1'b0 : core_prog_store_strobe;
    wire nxt_p0f      = (nxt_idle_o || nxt_pd_o) && ext_prog_mem;
    wire nxt_p2a      = nxt_idle_o && ext_prog_mem;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            core_run_ff <= 1'b1;
            osc_ff      <= 1'b1;
            pclk_ff     <= 1'b1;
            hold_ff     <= 1'b0;
            sfr_rst_ff  <= 1'b1;
            we_ff       <= 1'b0;
            ale_ff      <= 1'b1;
            prog_store_strobe_ff     <= 1'b1;
            p0f_ff      <= 1'b0;
            p2a_ff      <= 1'b0;
            isr_ff      <= 1'b0;
        end else begin
            core_run_ff <= nxt_core_run;
            osc_ff      <= nxt_osc;
            pclk_ff     <= nxt_pclk;
            hold_ff     <= nxt_hold;
            sfr_rst_ff  <= 1'b0;
            we_ff       <= nxt_we;
            ale_ff      <= nxt_ale;
            prog_store_strobe_ff     <= nxt_prog_store_strobe;
            p0f_ff      <= nxt_p0f;
            p2a_ff      <= nxt_p2a;
            isr_ff      <= wake_go;
        end
    end

    // RAM write enable is cleared by reset: contents survive it, guard gates it
    assign core_run          = core_run_ff;
    assign osc_run           = osc_ff;
    assign periph_clk_en     = pclk_ff;
    assign sfr_hold          = hold_ff;
    assign sfr_reset         = sfr_rst_ff;
    assign ram_we            = we_ff;
    assign idle_bit          = ctrl_ff[0];
    assign pdown_bit         = ctrl_ff[1];
    assign addr_latch_strobe = ale_ff;
    assign prog_store_strobe = prog_store_strobe_ff;
    assign port0_float       = p0f_ff;
    assign port2_addr_en     = p2a_ff;
    assign isr_start         = isr_ff;

    // ************************************************
    // Assertions
    // ************************************************
    a_idle_strobes_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(nxt_state == IPD_IDLE) && $past(rst_n) |-> ale_ff && prog_store_strobe_ff)
        else $error("Strobes not high in idle");
    a_pdown_strobes_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(nxt_pd_o) && $past(rst_n) |-> !ale_ff && !prog_store_strobe_ff)
        else $error("Strobes not low in power-down");
    a_idle_core_halt: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_idle && $past(in_idle) |-> !core_run && periph_clk_en)
        else $error("Core running or peripherals stopped in idle");
    a_idle_irq_exit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_idle && irq_pending |=> state_ff == IPD_RUN ##1 core_run)
        else $error("Idle did not end on interrupt");
    a_pd_prec: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_ff == IPD_RUN && ctrl_ff == 2'b11 |=> state_ff == IPD_PDOWN)
        else $error("Power-down did not win");
    a_pd_osc_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_ff == IPD_PDOWN && $past(state_ff == IPD_PDOWN) |-> !osc_run)
        else $error("Oscillator running in power-down");
    a_pd_no_exit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_ff == IPD_PDOWN && !ext_low |=> state_ff == IPD_PDOWN)
        else $error("Power-down left without wake source");
    a_pd_hold_regs: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_pd && $past(in_pd) |-> sfr_hold && !ram_we)
        else $error("Registers not held in power-down");
    a_edge_wake: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_ff == IPD_WAKE && wake_edge_select && ext_rise |=> isr_start)
        else $error("No service start on rising edge");
    a_timed_wake: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_ff == IPD_WAKE && !wake_edge_select && wk.done |=> isr_start && core_run)
        else $error("No resume after timed delay");
    a_ctrl_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_ff != IPD_RUN && nxt_state == IPD_RUN |=> ctrl_ff == 2'b00)
        else $error("Request bits not cleared on exit");
    a_reset_sfr: assert property (@(posedge ref_clk)
        !rst_n |=> sfr_reset && !ram_we)
        else $error("Registers not reset");
    a_ram_guard: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ram_block |=> !ram_we)
        else $error("RAM write during guard");
    a_idle_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_idle && $past(in_idle) |-> sfr_hold && !ram_we)
        else $error("State changed in idle");

    c_idle_entry: cover property (@(posedge ref_clk) state_ff == IPD_IDLE);
    c_pd_timed: cover property (@(posedge ref_clk) wk.done);
    c_pd_edge: cover property (@(posedge ref_clk) wake_go && wake_edge_select);
    c_guard: cover property (@(posedge ref_clk) ram_block);
endmodule : ipd_power_ctrl

/* dv/ipd_core_model.sv */
`timescale 1ns/1ps
// ************************************************
// Core-side partner: mode requests and bus strobes
// ************************************************
module ipd_core_model #(
    parameter int unsigned GAP = 400
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic isr_start,
    input  wire logic want_idle,
    input  wire logic want_pdown,
    output logic      idle_req_set,
    output logic      pdown_req_set,
    output logic      core_ale,
    output logic      core_prog_store_strobe
);
    int unsigned age_ff;
    logic        pd_ok;

    // Power-down waits out the settle gap after reset or wake
    assign pd_ok         = (age_ff == GAP);
    assign pdown_req_set = want_pdown && pd_ok;
    assign idle_req_set  = want_idle && (!want_pdown || pd_ok);

    // Strobes toggle every cycle so a stale value never passes for a held one
    always_ff @(posedge ref_clk) begin
        if (!rst_n || isr_start) begin
            age_ff <= 0;
        end else if (age_ff < GAP) begin
            age_ff <= age_ff + 1;
        end
        core_ale  <= rst_n ? ~core_ale : 1'b0;
        core_prog_store_strobe <= rst_n ? core_ale : 1'b0;
    end
endmodule : ipd_core_model

/* dv/idle_powerdown_control_bench.sv */
`timescale 1ns/1ps
module idle_powerdown_control_bench;
    import ipd_pkg::*;
    localparam int WAKE = 50;
    localparam int STARTUP = 20;
    typedef struct {logic [11:0] val; logic [11:0] msk; int at;} ipd_note_t;
    logic ref_clk, rst_n, want_idle, want_pdown, idle_req_set, pdown_req_set;
    logic wake_edge_select, ext_prog_mem, irq_pending, ext_irq0_en, ext_irq1_en;
    logic ext_irq0_pin, ext_irq1_pin, core_ale, core_prog_store_strobe, ram_we_req, e;
    logic core_run, osc_run, periph_clk_en, sfr_hold, sfr_reset, ram_we, idle_bit;
    logic pdown_bit, addr_latch_strobe, prog_store_strobe, port0_float, port2_addr_en;
    logic isr_start;
    logic [11:0] snap;
    ipd_note_t   q[$];
    int          mismatches, check_count, cyc, isr_n, k;

    assign snap = {core_run, osc_run, periph_clk_en, sfr_hold, sfr_reset, ram_we,
                   idle_bit, pdown_bit, addr_latch_strobe, prog_store_strobe,
                   port0_float, port2_addr_en};

    ipd_power_ctrl #(.WAKE_CYCLES(WAKE)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .idle_req_set(idle_req_set), .pdown_req_set(pdown_req_set),
        .wake_edge_select(wake_edge_select), .ext_prog_mem(ext_prog_mem),
        .irq_pending(irq_pending), .ext_irq0_en(ext_irq0_en), .ext_irq1_en(ext_irq1_en),
        .ext_irq0_pin(ext_irq0_pin), .ext_irq1_pin(ext_irq1_pin), .core_ale(core_ale),
        .core_prog_store_strobe(core_prog_store_strobe), .ram_we_req(ram_we_req), .core_run(core_run),
        .osc_run(osc_run), .periph_clk_en(periph_clk_en), .sfr_hold(sfr_hold),
        .sfr_reset(sfr_reset), .ram_we(ram_we), .idle_bit(idle_bit),
        .pdown_bit(pdown_bit), .addr_latch_strobe(addr_latch_strobe),
        .prog_store_strobe(prog_store_strobe), .port0_float(port0_float),
        .port2_addr_en(port2_addr_en), .isr_start(isr_start));

    ipd_core_model #(.GAP(400)) core (.ref_clk(ref_clk), .rst_n(rst_n),
        .isr_start(isr_start), .want_idle(want_idle), .want_pdown(want_pdown),
        .idle_req_set(idle_req_set), .pdown_req_set(pdown_req_set),
        .core_ale(core_ale), .core_prog_store_strobe(core_prog_store_strobe));

    // ************************************************
    // Clock, cycle count and checking helpers
    // ************************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) cyc <= cyc + 1;

    task automatic check(input bit ok, input string msg);
        check_count++;
        if (!ok) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check

    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : wt

    // Note the expected snapshot for the next falling edge, then let it pass
    task automatic expect_snap(input logic [11:0] v, input logic [11:0] m);
        q.push_back('{v, m, cyc + 1});
        wt(1);
    endtask : expect_snap

    // Monitor: compares a due snapshot note, and pairs each wake pulse with its note
    always @(negedge ref_clk) begin : mon
        ipd_note_t n;
        if (q.size() > 0 && q[0].msk != 0 && q[0].at == cyc) begin
            n = q.pop_front();
            check((snap & n.msk) === (n.val & n.msk), "output state differs");
        end
        if (isr_start === 1'b1) begin
            isr_n++;
            if (q.size() == 0 || q[0].msk != 0) begin
                check(1'b0, "unexpected service start");
            end else begin
                n = q.pop_front();
                check(cyc >= n.at, "service start too early");
            end
        end
    end

    task automatic do_reset(input int n);
        rst_n = 1'b0;
        wt(n);
        // Strobes idle high while reset holds the outputs
        expect_snap({8'b1110_1000, 4'b1100}, 12'hfff);
        rst_n = 1'b1;
        wt(2);
    endtask : do_reset

    // Ask for power-down; the core model holds it back until the gap has run
    task automatic enter_pdown(input logic both);
        want_pdown = 1'b1;
        want_idle = both;
        for (k = 0; k < 600 && pdown_bit !== 1'b1; k++) wt(1);
        want_pdown = 1'b0;
        want_idle = 1'b0;
        wt(4);
        // Both bits stay set in power-down, so the idle bit shows what was asked
        expect_snap({6'b0001_00, both, 1'b1, 2'b00, e, 1'b0}, 12'hfff);
    endtask : enter_pdown

    task automatic wait_isr(input int n0, input int lim);
        for (k = 0; k < lim && isr_n == n0; k++) wt(1);
        check(isr_n == n0 + 1, "no service start after wake");
        wt(3);
        // Core strobes toggle in run, so they are left out of the mask
        expect_snap(12'he00, 12'hfc3);
    endtask : wait_isr

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        report_and_stop();
    end

    // ************************************************
    // Test sequence
    // ************************************************
    initial begin
        {want_idle, want_pdown, irq_pending, ram_we_req, wake_edge_select} = '0;
        {ext_irq0_en, ext_irq1_en, ext_irq0_pin, ext_irq1_pin} = 4'b1111;
        cyc = 0;
        void'($urandom(32'hb88f1116));
        e = $urandom_range(0, 1);
        ext_prog_mem = e;
        wt(1);
        do_reset(5);
        expect_snap(12'he00, 12'hfc3);
        $display("test reset done");
        // Idle entry, then wake by pending interrupt
        for (int i = 0; i < 2; i++) begin
            e = $urandom_range(0, 1);
            ext_prog_mem = e;
            ram_we_req = $urandom_range(0, 1);
            want_idle = 1'b1;
            wt(1);
            want_idle = 1'b0;
            wt(4);
            expect_snap({8'b0111_0010, 2'b11, e, e}, 12'hfff);
            irq_pending = 1'b1;
            wt(1);
            irq_pending = 1'b0;
            wt(2);
            // Back in run the random write request passes straight through
            expect_snap({5'b1110_0, ram_we_req, 6'b00_0000}, 12'hfc3);
        end
        $display("test idle done");
        // Reset out of idle keeps RAM writes blocked for two machine cycles
        want_idle = 1'b1;
        wt(1);
        want_idle = 1'b0;
        ram_we_req = 1'b1;
        wt(5);
        do_reset(1);
        wt(14);
        expect_snap(12'h000, 12'h040);
        wt(12);
        expect_snap(12'h040, 12'h040);
        ram_we_req = 1'b0;
        $display("test idle reset done");
        // Both requests at once, wake on the rising edge of pin 0
        wake_edge_select = 1'b1;
        ext_irq1_en = 1'b0;
        enter_pdown(1'b1);
        irq_pending = 1'b1;
        ext_irq1_pin = 1'b0;
        wt(10);
        expect_snap({8'b0001_0001, 2'b00, e, 1'b0}, 12'hfdf);
        irq_pending = 1'b0;
        ext_irq1_pin = 1'b1;
        k = isr_n;
        ext_irq0_pin = 1'b0;
        wt(STARTUP);
        q.push_back('{12'h000, 12'h000, cyc + 1});
        ext_irq0_pin = 1'b1;
        wait_isr(k, 20);
        $display("test edge wake done");
        // Timed wake from the falling edge of pin 1
        wake_edge_select = 1'b0;
        ext_irq1_en = 1'b1;
        e = $urandom_range(0, 1);
        ext_prog_mem = e;
        enter_pdown(1'b0);
        k = isr_n;
        q.push_back('{12'h000, 12'h000, cyc + WAKE});
        ext_irq1_pin = 1'b0;
        wt(STARTUP);
        ext_irq1_pin = 1'b1;
        wait_isr(k, WAKE + 20);
        $display("test timed wake done");
        // Reset out of power-down
        enter_pdown(1'b0);
        do_reset(3);
        expect_snap(12'he00, 12'hfc3);
        $display("test power-down reset done");
        report_and_stop();
    end
endmodule : idle_powerdown_control_bench
